// file: verilog/usp_pkg.sv
// usp_pkg: constants shared by the spi master serial port
package usp_pkg;

  // ----------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [9:0]  IDX_STATUS    = 10'h0C0;
  localparam logic [9:0]  IDX_CTRL      = 10'h0C1;
  localparam logic [9:0]  IDX_FORMAT    = 10'h0C2;
  localparam logic [9:0]  IDX_DIV_LOW   = 10'h0C4;
  localparam logic [9:0]  IDX_DIV_HIGH  = 10'h0C5;
  localparam logic [9:0]  IDX_DATA      = 10'h0C6;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int          ST_RX_DONE    = 7;
  localparam int          ST_TX_DONE    = 6;
  localparam int          ST_BUF_EMPTY  = 5;
  localparam int          CT_RX_EN      = 4;
  localparam int          CT_TX_EN      = 3;
  localparam int          FM_MODE_HI    = 7;
  localparam int          FM_MODE_LO    = 6;
  localparam int          FM_ORDER      = 2;
  localparam int          FM_PHASE      = 1;
  localparam int          FM_POLARITY   = 0;
  localparam logic [1:0]  MODE_SPI      = 2'h3;

  // ----------------------------------------
  // reset values and sizes
  // ----------------------------------------
  localparam logic [7:0]  RST_CTRL      = 8'h00;
  localparam logic [7:0]  RST_FORMAT    = 8'h06;
  localparam logic [7:0]  RST_DIV_LOW   = 8'h00;
  localparam logic [3:0]  RST_DIV_HIGH  = 4'h0;
  localparam int          DIV_W         = 12;
  localparam int          FRAME_BITS    = 8;
  localparam logic [3:0]  LAST_EDGE     = 4'hF;
  localparam int          RX_DEPTH      = 2;

  typedef enum logic {
    USP_IDLE  = 1'b0,
    USP_SHIFT = 1'b1
  } usp_state_t;

endpackage

// file: verilog/usp_rx_buf.sv
// usp_rx_buf: small receive queue with registered head output
`timescale 1ns/1ps
`default_nettype none
module usp_rx_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // write side
  input  wire logic         push,
  input  wire logic [W-1:0] pushData,
  // read side
  input  wire logic         pop,
  output logic [W-1:0]      headData,
  output logic              notEmpty,
  output logic              full
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d, rdNext;
  logic [PW:0]   count_q, count_d;
  logic [W-1:0]  head_q, head_d;
  logic          doPush, doPop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    doPop   = pop && (count_q != '0);
    // a full queue drops the newest byte, older ones survive
    doPush  = push && (count_q != (PW+1)'(DEPTH));
    wrPtr_d = doPush ? bump(wrPtr_q) : wrPtr_q;
    rdNext  = bump(rdPtr_q);
    rdPtr_d = doPop ? rdNext : rdPtr_q;
    count_d = count_q + (PW+1)'(doPush) - (PW+1)'(doPop);
    head_d  = head_q;
    if (count_q == '0 && doPush) begin
      head_d = pushData;
    end else if (doPop) begin
      head_d = (count_q > (PW+1)'(1)) ? mem[rdNext] : pushData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      head_q  <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      head_q  <= head_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= pushData;
    end
  end

  assign headData = head_q;
  assign notEmpty = (count_q != '0);
  assign full     = (count_q == (PW+1)'(DEPTH));
endmodule
`default_nettype wire

// file: verilog/usp_spi_master.sv
// usp_spi_master: serial port in master spi mode with apb registers
//
// What this block does
// - phase bit picks leading or trailing sample
// - polarity 0, phase 1: change rising, sample falling
// - polarity sets clock idle level
// - 12-bit divider split high/low registers
// - low divider write reloads prescaler immediately
// - mode field 11 enables master spi
// - parity and recovery off, one controller
// - internal clock only, clock pin output
// - bit rate is clock over 2(div+1)
// - spi modes 0-3 from polarity and phase
// - shift out and sample on opposite edges
// - same register addresses in all modes
// - full duplex, double buffered, selectable order
// - order bit one sends lsb first
// - eight bit frames, idle line high
// - data write starts transfer, buffer feeds shifter
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module usp_spi_master #(
  parameter int RX_BUF_DEPTH = usp_pkg::RX_DEPTH
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [usp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // serial pins
  input  wire logic                serialInPin,
  output logic                     serialOutPin,
  output logic                     serialOutOe,
  output logic                     transferClockPin,
  output logic                     transferClockOe
);
  import usp_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]             ctrl_q, ctrl_d, format_q, format_d;
  logic [7:0]             divLow_q, divLow_d;
  logic [3:0]             divHigh_q, divHigh_d;
  logic [DIV_W-1:0]       baudCnt_q, baudCnt_d;
  logic [7:0]             txBuf_q, txBuf_d, txSh_q, txSh_d, rxSh_q, rxSh_d;
  logic                   bufFull_q, bufFull_d, txDone_q, txDone_d;
  logic [3:0]             edgeCnt_q, edgeCnt_d;
  logic                   clk_q, clk_d, out_q, out_d;
  logic                   clkOe_q, clkOe_d, outOe_q, outOe_d;
  usp_state_t             state_q, state_d;
  logic [31:0]            prdata_q, prdata_d;
  logic                   pready_q, pready_d, pslverr_q, pslverr_d;

  logic                   wrEn, rdEn, setup, mapped;
  logic [9:0]             idx;
  logic                   spiMode, tick, lsbFirst, phase, polarity;
  logic                   rxPush, rxPop, rxNotEmpty, rxFull;
  logic [7:0]             rxHead, rxByte;
  logic [DIV_W-1:0]       divider;

  // ----------------------------------------
  // bit helpers
  // ----------------------------------------
  function automatic logic frontBit(input logic [7:0] v, input logic lsb);
    frontBit = lsb ? v[0] : v[FRAME_BITS-1];
  endfunction

  function automatic logic [7:0] advance(input logic [7:0] v, input logic lsb);
    advance = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] takeIn(input logic [7:0] v, input logic b,
                                        input logic lsb);
    takeIn = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // fixed addresses
  // decode ignores the mode field entirely
  always_comb begin
    idx    = paddr[ADDR_W-1:2];
    mapped = (idx == IDX_STATUS) || (idx == IDX_CTRL) ||
             (idx == IDX_FORMAT) || (idx == IDX_DIV_LOW) ||
             (idx == IDX_DIV_HIGH) || (idx == IDX_DATA);
    setup  = psel && !penable;
    wrEn   = psel && penable && pready_q && pwrite && mapped;
    rdEn   = psel && penable && pready_q && !pwrite && mapped;
  end

  assign spiMode  = (format_q[FM_MODE_HI:FM_MODE_LO] == MODE_SPI);
  assign lsbFirst = format_q[FM_ORDER];
  assign phase    = format_q[FM_PHASE];
  assign polarity = format_q[FM_POLARITY];
  assign divider  = {divHigh_q, divLow_q};
  assign tick     = (baudCnt_q == '0);
  // with phase 1 the last edge is itself a sample edge, so fold that bit in;
  // with phase 0 the byte is already complete before the last edge
  assign rxByte   = phase ? takeIn(rxSh_q, serialInPin, lsbFirst) : rxSh_q;

  // ----------------------------------------
  // registers and apb answer
  // ----------------------------------------
  always_comb begin
    ctrl_d    = ctrl_q;
    format_d  = format_q;
    divLow_d  = divLow_q;
    divHigh_d = divHigh_q;
    pready_d  = setup;
    pslverr_d = setup && !mapped;
    prdata_d  = '0;
    if (setup) begin
      case (paddr[ADDR_W-1:2])
        IDX_STATUS: begin
          prdata_d[ST_RX_DONE]   = rxNotEmpty;
          prdata_d[ST_TX_DONE]   = txDone_q;
          prdata_d[ST_BUF_EMPTY] = !bufFull_q;
        end
        IDX_CTRL:     prdata_d[7:0] = ctrl_q;
        IDX_FORMAT:   prdata_d[7:0] = format_q;
        IDX_DIV_LOW:  prdata_d[7:0] = divLow_q;
        IDX_DIV_HIGH: prdata_d[3:0] = divHigh_q;
        IDX_DATA:     prdata_d[7:0] = rxHead;
        default:      prdata_d      = '0;
      endcase
    end
    if (wrEn) begin
      case (idx)
        IDX_CTRL:     ctrl_d    = pwdata[7:0];
        // parity and stop fields stored, unused here
        IDX_FORMAT:   format_d  = pwdata[7:0];
        IDX_DIV_LOW:  divLow_d  = pwdata[7:0];
        IDX_DIV_HIGH: divHigh_d = pwdata[3:0];
        default:      ctrl_d    = ctrl_q;
      endcase
    end
  end

  assign rxPop = rdEn && (idx == IDX_DATA);

  // ----------------------------------------
  // baud generator
  // ----------------------------------------
  always_comb begin
    baudCnt_d = tick ? divider : baudCnt_q - 1'b1;
    // low write restarts prescaler
    // high half comes from its register, so write high before low
    if (wrEn && idx == IDX_DIV_LOW) begin
      baudCnt_d = {divHigh_q, pwdata[7:0]};
    end
  end

  // ----------------------------------------
  // transfer controller
  // ----------------------------------------
  always_comb begin
    state_d   = state_q;
    txBuf_d   = txBuf_q;
    bufFull_d = bufFull_q;
    txSh_d    = txSh_q;
    rxSh_d    = rxSh_q;
    edgeCnt_d = edgeCnt_q;
    clk_d     = clk_q;
    out_d     = out_q;
    txDone_d  = txDone_q;
    rxPush    = 1'b0;
    // clock pin is driven only in spi mode with the transmitter enabled
    clkOe_d   = spiMode && ctrl_q[CT_TX_EN];
    outOe_d   = spiMode && ctrl_q[CT_TX_EN];
    // status clear: write one; a same-cycle set below wins
    if (wrEn && idx == IDX_STATUS && pwdata[ST_TX_DONE]) begin
      txDone_d = 1'b0;
    end
    if (wrEn && idx == IDX_DATA && !bufFull_q) begin
      txBuf_d   = pwdata[7:0];
      bufFull_d = 1'b1;
    end
    case (state_q)
      USP_IDLE: begin
        clk_d = polarity;
        out_d = 1'b1;
        // buffer hands over to the shifter
        if (spiMode && ctrl_q[CT_TX_EN] && bufFull_q) begin
          state_d   = USP_SHIFT;
          bufFull_d = 1'b0;
          edgeCnt_d = '0;
          if (!phase) begin
            out_d  = frontBit(txBuf_q, lsbFirst);
            txSh_d = advance(txBuf_q, lsbFirst);
          end else begin
            txSh_d = txBuf_q;
          end
        end
      end
      USP_SHIFT: begin
        if (tick) begin
          clk_d     = !clk_q;
          edgeCnt_d = edgeCnt_q + 1'b1;
          // leading edge samples when phase is 0
          if (edgeCnt_q[0] == phase) begin
            rxSh_d = takeIn(rxSh_q, serialInPin, lsbFirst);
          end else begin
            out_d  = frontBit(txSh_q, lsbFirst);
            txSh_d = advance(txSh_q, lsbFirst);
          end
          if (edgeCnt_q == LAST_EDGE) begin
            state_d = USP_IDLE;
            rxPush  = ctrl_q[CT_RX_EN];
            if (!bufFull_d) begin
              txDone_d = 1'b1;
            end
          end
        end
        if (!spiMode || !ctrl_q[CT_TX_EN]) begin
          state_d = USP_IDLE;
        end
      end
      default: state_d = USP_IDLE;
    endcase
  end

  // polarity fixes which level is idle, so setup
  // and sample land on the edge directions given by the mode table
  // ----------------------------------------
  // flip-flops
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q    <= RST_CTRL;
      format_q  <= RST_FORMAT;
      divLow_q  <= RST_DIV_LOW;
      divHigh_q <= RST_DIV_HIGH;
      baudCnt_q <= '0;
      state_q   <= USP_IDLE;
      txBuf_q   <= 8'h00;
      bufFull_q <= 1'b0;
      txSh_q    <= 8'h00;
      rxSh_q    <= 8'h00;
      edgeCnt_q <= 4'h0;
      clk_q     <= 1'b0;
      out_q     <= 1'b1;
      txDone_q  <= 1'b0;
      clkOe_q   <= 1'b0;
      outOe_q   <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      format_q  <= format_d;
      divLow_q  <= divLow_d;
      divHigh_q <= divHigh_d;
      baudCnt_q <= baudCnt_d;
      state_q   <= state_d;
      txBuf_q   <= txBuf_d;
      bufFull_q <= bufFull_d;
      txSh_q    <= txSh_d;
      rxSh_q    <= rxSh_d;
      edgeCnt_q <= edgeCnt_d;
      clk_q     <= clk_d;
      out_q     <= out_d;
      txDone_q  <= txDone_d;
      clkOe_q   <= clkOe_d;
      outOe_q   <= outOe_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // receive queue
  // ----------------------------------------
  // push takes the finished byte on the last edge of the frame
  usp_rx_buf #(
    .W     (FRAME_BITS),
    .DEPTH (RX_BUF_DEPTH)
  ) u_rx_buf (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .push     (rxPush),
    .pushData (rxByte),
    .pop      (rxPop),
    .headData (rxHead),
    .notEmpty (rxNotEmpty),
    .full     (rxFull)
  );

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign serialOutPin     = out_q;
  assign serialOutOe      = outOe_q;
  assign transferClockPin = clk_q;
  assign transferClockOe  = clkOe_q;
endmodule
`default_nettype wire

// file: tb/usp_spi_master_props.sv
// usp_spi_master_props: port assertions for the spi master serial port
`timescale 1ns/1ps
`default_nettype none
module usp_spi_master_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        serialInPin,
  input wire logic        serialOutPin,
  input wire logic        serialOutOe,
  input wire logic        transferClockPin,
  input wire logic        transferClockOe
);
  import usp_pkg::*;
  // ----
  // shadow state
  // ----
  logic [7:0]  fmt_q, fmt_d, ctl_q, ctl_d, lo_q, lo_d;
  logic [3:0]  hi_q, hi_d;
  logic [19:0] gap_q, gap_d;
  logic        pin_q, wr, cfgOk, mapped;
  logic [9:0]  idx;
  assign idx    = paddr[11:2];
  assign wr     = psel && penable && pready && pwrite && !pslverr;
  assign cfgOk  = fmt_q[FM_MODE_HI:FM_MODE_LO] == MODE_SPI && ctl_q[CT_TX_EN];
  assign mapped = idx inside {IDX_STATUS, IDX_CTRL, IDX_FORMAT, IDX_DIV_LOW, IDX_DIV_HIGH,
                              IDX_DATA};
  always_comb begin
    fmt_d = (wr && idx == IDX_FORMAT) ? pwdata[7:0] : fmt_q;
    ctl_d = (wr && idx == IDX_CTRL) ? pwdata[7:0] : ctl_q;
    lo_d  = (wr && idx == IDX_DIV_LOW) ? pwdata[7:0] : lo_q;
    hi_d  = (wr && idx == IDX_DIV_HIGH) ? pwdata[3:0] : hi_q;
    // wide gap count so idle stretches under 2^20 cycles never wrap
    gap_d = (transferClockPin != pin_q) ? 20'h00000 : gap_q + 20'h00001;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fmt_q <= RST_FORMAT;
      ctl_q <= RST_CTRL;
      lo_q  <= RST_DIV_LOW;
      hi_q  <= RST_DIV_HIGH;
      gap_q <= 20'h00000;
      pin_q <= 1'b0;
    end else begin
      fmt_q <= fmt_d;
      ctl_q <= ctl_d;
      lo_q  <= lo_d;
      hi_q  <= hi_d;
      gap_q <= gap_d;
      pin_q <= transferClockPin;
    end
  end
  // ----
  // assertions
  // ----
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no pready after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_unmapped;
    pready |-> pslverr == !mapped;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("pslverr wrong");
  property p_read_top;
    pready && !pwrite |-> prdata[31:8] == 24'h000000;
  endproperty
  a_read_top: assert property (p_read_top) else $error("read upper bits set");
  property p_div_read;
    pready && !pwrite && (idx == IDX_DIV_LOW || idx == IDX_DIV_HIGH)
      |-> prdata[7:0] == ((idx == IDX_DIV_LOW) ? lo_q : {4'h0, hi_q});
  endproperty
  a_div_read: assert property (p_div_read) else $error("divider readback wrong");
  property p_oe_pair;
    transferClockOe == serialOutOe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
  property p_oe_mode;
    cfgOk == $past(cfgOk) |-> serialOutOe == cfgOk;
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("enable not mode based");
  property p_idle;
    !serialOutOe && !$past(serialOutOe) && fmt_q[FM_POLARITY] == $past(fmt_q[FM_POLARITY])
      |-> transferClockPin == fmt_q[FM_POLARITY] && serialOutPin;
  endproperty
  a_idle: assert property (p_idle) else $error("idle levels wrong");
  property p_clk_gap;
    transferClockPin != pin_q |-> gap_q >= {8'h00, hi_q, lo_q};
  endproperty
  a_clk_gap: assert property (p_clk_gap) else $error("clock toggles too fast");
endmodule
bind usp_spi_master usp_spi_master_props usp_spi_master_props_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serialInPin(serialInPin), .serialOutPin(serialOutPin), .serialOutOe(serialOutOe),
  .transferClockPin(transferClockPin), .transferClockOe(transferClockOe)
);
`default_nettype wire

// file: tb/usp_slave_model.sv
// usp_slave_model: behavioural spi slave on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module usp_slave_model (
  // spi wires
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  // mode and data
  input  wire logic       rst_n,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] txByte,
  output logic [7:0]      rxByte,
  output int              rxCount
);
  int         edgeNo;
  logic [7:0] cur;
  function automatic int pos(input int k);
    return lsb ? k : 7 - k;
  endfunction
  initial begin
    edgeNo  = 0;
    rxCount = 0;
    miso    = 1'b0;
  end
  always @(txByte or cpha or lsb) begin
    if (edgeNo == 0 && !cpha) begin
      miso = txByte[pos(0)];
    end
  end
  always @(sclk) begin
    // an idle level change is not a frame edge
    if (rst_n === 1'b1 && !(edgeNo == 0 && sclk === cpol)) begin
      if (edgeNo == 0) cur = txByte;
      if (edgeNo % 2 == int'(cpha)) begin
        rxByte[pos(edgeNo / 2)] = mosi;
      end else if (cpha) begin
        miso = cur[pos(edgeNo / 2)];
      end else if (edgeNo < 15) begin
        miso = cur[pos(edgeNo / 2 + 1)];
      end
      edgeNo++;
      if (edgeNo == 16) begin
        edgeNo = 0;
        rxCount++;
        miso = cpha ? ~miso : txByte[pos(0)];
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/test_usart_master_spi_clocking.sv
// test_usart_master_spi_clocking: self-checking bench for the spi master port
`timescale 1ns/1ps
`default_nettype none
module test_usart_master_spi_clocking;
  import usp_pkg::*;
  // ----
  // signals and queues
  // ----
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  localparam logic [32:0] ERR = 33'h100000000;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        miso, mosi, mosiOe, sclk, sclkOe, cpol, cpha, lsb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [7:0]  slvTx, slvRx, tx;
  logic [32:0] expQ[$], mskQ[$];
  logic [7:0]  wireQ[$];
  int          rxCount, fail_count, n_compared, seed, i;
  usp_spi_master usp_spi_master_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serialInPin(miso), .serialOutPin(mosi), .serialOutOe(mosiOe),
    .transferClockPin(sclk), .transferClockOe(sclkOe));
  usp_slave_model usp_slave_model_inst (
    .sclk(sclk), .mosi(mosi), .miso(miso), .rst_n(rst_n), .cpol(cpol), .cpha(cpha),
    .lsb(lsb), .txByte(slvTx), .rxByte(slvRx), .rxCount(rxCount));
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d,
                     input logic [32:0] exp, input logic [32:0] msk);
    int n;
    expQ.push_back(exp);
    mskQ.push_back(msk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      close_out();
    end
    rdData = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wreg(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 33'h0, ERR);
  endtask
  task automatic rreg(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, {1'b0, exp}, ALL);
  endtask
  task automatic done();
    int n;
    n = 0;
    rdData = 32'h0;
    while (rdData[ST_TX_DONE] !== 1'b1 && n < 2000) begin
      apb(1'b0, IDX_STATUS, 32'h0, 33'h0, ERR);
      n++;
    end
    if (rdData[ST_TX_DONE] !== 1'b1) begin
      fail_count++;
      close_out();
    end
    wreg(IDX_STATUS, 32'h1 << ST_TX_DONE);
    check("sclk idle", {32'h0, sclk}, {32'h0, cpol});
    check("out idle", {32'h0, mosi}, 33'h1);
    check("pin enables", {31'h0, sclkOe, mosiOe}, 33'h3);
  endtask
  // ----
  // result watchers
  // ----
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && expQ.size() > 0) begin
      check("apb", {pslverr, prdata} & mskQ[0], expQ[0] & mskQ[0]);
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
  end
  always @(rxCount) begin
    check("wire", {25'h0, slvRx},
          {25'h0, (wireQ.size() > 0) ? wireQ.pop_front() : 8'hxx});
  end
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, psel, penable, pwrite, cpol, cpha, lsb} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    slvTx = 8'h00;
    seed = 11;
    fail_count = 0;
    n_compared = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rreg(IDX_FORMAT, {24'h0, RST_FORMAT});
    rreg(IDX_CTRL, {24'h0, RST_CTRL});
    rreg(IDX_DIV_LOW, {24'h0, RST_DIV_LOW});
    rreg(IDX_DIV_HIGH, {28'h0, RST_DIV_HIGH});
    apb(1'b1, 10'h0C3, 32'hFFFFFFFF, ERR, ERR);
    apb(1'b0, 10'h0C3, 32'h0, ERR, ALL);
    wreg(IDX_DIV_HIGH, 32'hFFFFFFFF);
    wreg(IDX_DIV_LOW, 32'h000000FF);
    rreg(IDX_DIV_HIGH, 32'h0000000F);
    rreg(IDX_DIV_LOW, 32'h000000FF);
    wreg(IDX_DIV_HIGH, 32'h0);
    wreg(IDX_DIV_LOW, 32'h0);
    for (i = 0; i < 8; i++) begin
      // timing changed only while idle, and in spi mode after the first pass
      cpol <= i[0];
      cpha <= i[1];
      lsb  <= i[2];
      wreg(IDX_DIV_LOW, i % 3);
      wreg(IDX_FORMAT, {24'h0, MODE_SPI, 3'b000, i[2], i[1], i[0]});
      // enable once the mode is set
      if (i == 0) wreg(IDX_CTRL, (32'h1 << CT_RX_EN) | (32'h1 << CT_TX_EN));
      slvTx <= 8'($random(seed));
      tx = 8'($random(seed));
      wireQ.push_back(tx);
      wreg(IDX_DATA, {24'h0, tx});
      if (i == 7) begin
        wireQ.push_back(~tx);
        wreg(IDX_DATA, {24'h0, ~tx});
      end
      done();
      rreg(IDX_DATA, {24'h0, slvTx});
      if (i == 7) rreg(IDX_DATA, {24'h0, slvTx});
    end
    close_out();
  end
endmodule
`default_nettype wire
